// ### set_features_regs.svh
// Constants for the set-features subcommand decoder: offsets, codes, fields, defaults.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SET_FEATURES_REGS_SVH
`define SET_FEATURES_REGS_SVH

// Word offsets on the register bus (byte address = 4 * index)
`define OFS_COMMAND      4'h0
`define OFS_FEATURE      4'h1
`define OFS_SECCOUNT     4'h2
`define OFS_CYLLOW       4'h3
`define OFS_CYLHIGH      4'h4
`define OFS_STATUS       4'h5
`define OFS_SETTINGS     4'h6
`define OFS_MODES        4'h7
`define OFS_APMLEVEL     4'h8
`define OFS_CURRLIMIT    4'h9
`define OFS_FLUSHDONE    4'ha
`define ADDR_LSB         2

// Command and subcommand codes
`define CMD_SET_FEATURES 8'hef
`define SF_8BIT_ON       8'h01
`define SF_8BIT_OFF      8'h81
`define SF_WCACHE_ON     8'h02
`define SF_WCACHE_OFF    8'h82
`define SF_XFER_MODE     8'h03
`define SF_APM_ON        8'h05
`define SF_APM_OFF       8'h85
`define SF_EXTPWR_ON     8'h09
`define SF_EXTPWR_OFF    8'h89
`define SF_PL1_ON        8'h0a
`define SF_PL1_OFF       8'h8a
`define SF_RLA_OFF       8'h55
`define SF_RLA_ON        8'haa
`define SF_POR_KEEP      8'h66
`define SF_POR_RESTORE   8'hcc
`define SF_NOP_A         8'h69
`define SF_NOP_B         8'h96
`define SF_NOP_C         8'h97
`define SF_CURR_LIMIT    8'h9a
`define SF_LONG_4BYTE    8'hbb

// Transfer type codes in Sector Count bits 7:3, mode values in bits 2:0
`define XT_PIO_DEFAULT   5'h00
`define XT_PIO_FLOW      5'h01
`define XT_MWDMA         5'h04
`define XT_UDMA          5'h08
`define XM_NO_IORDY      3'h1
`define PIO_IORDY_MIN    3'h3

// Power management level bounds
`define APM_RSVD_LOW     8'h00
`define APM_RSVD_HIGH    8'hff
`define APM_MAX_PERF     8'hfe

// Status bit positions
`define ST_BUSY          0
`define ST_ERROR         1
`define ST_ABORT         2
`define ST_FLUSHREQ      3

// Settings bit positions
`define SB_8BIT          0
`define SB_WCACHE        1
`define SB_APM           2
`define SB_EXTPWR        3
`define SB_PL1           4
`define SB_RLA           5
`define SB_LONG4         6
`define SB_PORKEEP       7
`define SB_IORDYOFF      8
`define SB_IORDYUSE      9

// Mode register fields
`define MB_PIO_LSB       0
`define MB_DMA_LSB       4
`define MB_MWDMA         8
`define MB_UDMA          9

`endif

// ### set_features_pkg.sv
// Types for the set-features subcommand decoder.
// Assumes the constants header is on the include path.
package set_features_pkg;
    `include "set_features_regs.svh"

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } cmd_state_e;

    typedef enum logic [1:0] {
        DMA_NONE = 2'b00,
        DMA_MW   = 2'b01,
        DMA_U    = 2'b10
    } dma_kind_e;
endpackage

// ### set_features_subcommand_decoder.sv
// Set-features subcommand decoder and feature state holder behind an Avalon-MM slave.
// Assumes a synchronous host-side task-file bridge; flush engine answers on flushDone.
// Functional notes
// - Command EFh runs set features; subcommand from Feature, parameter from Sector Count.
// - Subcommand 01h enables 8-bit transfers, 81h disables them.
// - In 8-bit mode data uses D[7:0] only; wide I/O indicator stays low.
// - 02h enables write cache; 82h disables after flushing cache before completion.
// - Subcommand 03h splits Sector Count: type in bits 7:3, mode in 2:0.
// - Types: 00000b default PIO, 00001b PIO flow, 00100b MWDMA, 01000b UDMA.
// - Default PIO mode 001b also disables ready/wait where supported; 000b plain default.
// - Exactly one PIO mode, and one DMA mode if DMA-capable, always selected.
// - Every mode up to the highest supported of each type is accepted.
// - Selecting UDMA clears MWDMA; selecting MWDMA clears UDMA.
// - Multiword DMA is refused while a PC Card interface mode is configured.
// - Ready/wait flow control is honoured whenever PIO mode is 3 or higher.
// - 05h enables power management with the Sector Count level; 85h disables.
// - Levels 01h-FEh valid in bands; 00h and FFh are reserved.
// - Valid levels are stored but do not change performance or power.
// - 0Ah/8Ah enable/disable Power Level 1; default disabled, all commands still run.
// - 55h/AAh disable/enable look-ahead; BBh sets 4-byte long data; 55h, BBh default.
// - 69h, 96h and 97h are accepted and do nothing.
// - 9Ah stores Sector Count as quarter of maximum average current in mA.
// - After 9Ah, Cylinder Low gets minimum and Cylinder High gets maximum.
// - Current limit defaults to maximum; out-of-range requests are clamped.
// - 66h stops soft reset restoring defaults; CCh re-enables; restoring is default.
// - 09h enables extended power operations; 89h disables them.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "set_features_regs.svh"
module set_features_subcommand_decoder
    import set_features_pkg::*;
#(
    parameter logic [2:0] PIO_MAX   = 3'h6,
    parameter logic [2:0] MWDMA_MAX = 3'h4,
    parameter logic [2:0] UDMA_MAX  = 3'h4,
    parameter bit         DMA_CAP   = 1'b1,
    parameter bit         IORDY_OFF = 1'b1,
    parameter logic [7:0] CURR_MIN  = 8'h01,
    parameter logic [7:0] CURR_MAX  = 8'h32
)(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        softRst,
    input  wire logic        pcCardMode,
    input  wire logic        dataRegAccess,
    input  wire logic        flushDone,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             wide_io_select_indicator,
    output logic             eightBitMode,
    output logic             iordyEnable,
    output logic             flushReq
);
    if (PIO_MAX > 3'h6 || CURR_MIN > CURR_MAX)
    begin
        $error("Unsupported parameter set");
    end

    cmd_state_e  state_q;
    logic [7:0]  feat_q;
    logic [7:0]  secCnt_q;
    logic [7:0]  cylLow_q;
    logic [7:0]  cylHigh_q;
    logic        err_q;
    logic        abort_q;
    logic        acc_q;
    logic        set8_q;
    logic        wcache_q;
    logic        apm_q;
    logic        extPwr_q;
    logic        pl1_q;
    logic        rla_q;
    logic        long4_q;
    logic        porKeep_q;
    logic        iordyOff_q;
    logic [2:0]  pioMode_q;
    logic [2:0]  dmaMode_q;
    dma_kind_e   dmaKind_q;
    logic [7:0]  apmLvl_q;
    logic [7:0]  currLim_q;
    logic        cmdGo;
    logic        restore;
    logic [4:0]  xType;
    logic [2:0]  xMode;
    logic        known;
    logic        badParam;

    function automatic logic [7:0] clampCurr(input logic [7:0] v);
        if (v < CURR_MIN)
            return CURR_MIN;
        if (v > CURR_MAX)
            return CURR_MAX;
        return v;
    endfunction

    function automatic logic validLevel(input logic [7:0] v);
        return v != `APM_RSVD_LOW && v != `APM_RSVD_HIGH;
    endfunction

    // A write lands in one cycle; waitrequest only covers the read data register stage.
    assign avs_waitrequest = avs_read & ~acc_q;

    assign cmdGo = avs_write && avs_address == `OFS_COMMAND
                   && avs_writedata[7:0] == `CMD_SET_FEATURES && state_q == ST_IDLE;
    assign restore = softRst && !porKeep_q;
    assign xType = secCnt_q[7:3];
    assign xMode = secCnt_q[2:0];

    always_comb
    begin
        known = 1'b1;
        badParam = 1'b0;
        unique case (feat_q)
            `SF_8BIT_ON, `SF_8BIT_OFF, `SF_WCACHE_ON, `SF_WCACHE_OFF,
            `SF_APM_OFF, `SF_EXTPWR_ON, `SF_EXTPWR_OFF, `SF_PL1_ON, `SF_PL1_OFF,
            `SF_RLA_OFF, `SF_RLA_ON, `SF_POR_KEEP, `SF_POR_RESTORE, `SF_NOP_A,
            `SF_NOP_B, `SF_NOP_C, `SF_CURR_LIMIT, `SF_LONG_4BYTE:
                known = 1'b1;
            `SF_APM_ON:
                badParam = !validLevel(secCnt_q);
            `SF_XFER_MODE:
            begin
                unique case (xType)
                    `XT_PIO_DEFAULT:
                        badParam = xMode > `XM_NO_IORDY;
                    `XT_PIO_FLOW:
                        badParam = xMode > PIO_MAX;
                    `XT_MWDMA:
                        badParam = !DMA_CAP || xMode > MWDMA_MAX || pcCardMode;
                    `XT_UDMA:
                        badParam = !DMA_CAP || xMode > UDMA_MAX;
                    default:
                        badParam = 1'b1;
                endcase
            end
            default:
                known = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            state_q <= ST_IDLE;
        else
            unique case (state_q)
                ST_IDLE:
                    if (cmdGo)
                        state_q <= ST_EXEC;
                ST_EXEC:
                    if (known && !badParam && feat_q == `SF_WCACHE_OFF && wcache_q)
                        state_q <= ST_FLUSH;
                    else
                        state_q <= ST_IDLE;
                ST_FLUSH:
                    if (flushDone)
                        state_q <= ST_IDLE;
            endcase
    end

    assign flushReq = state_q == ST_FLUSH;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            feat_q <= 8'h00;
            secCnt_q <= 8'h00;
        end
        else if (avs_write && state_q == ST_IDLE)
        begin
            if (avs_address == `OFS_FEATURE)
                feat_q <= avs_writedata[7:0];
            if (avs_address == `OFS_SECCOUNT)
                secCnt_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            err_q <= 1'b0;
            abort_q <= 1'b0;
        end
        else if (cmdGo)
        begin
            err_q <= 1'b0;
            abort_q <= 1'b0;
        end
        else if (state_q == ST_EXEC && (!known || badParam))
        begin
            err_q <= 1'b1;
            abort_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cylLow_q <= 8'h00;
            cylHigh_q <= 8'h00;
        end
        else if (state_q == ST_EXEC && feat_q == `SF_CURR_LIMIT)
        begin
            cylLow_q <= CURR_MIN;
            cylHigh_q <= CURR_MAX;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || restore)
        begin
            set8_q <= 1'b0;
            wcache_q <= 1'b0;
            apm_q <= 1'b0;
            extPwr_q <= 1'b0;
            pl1_q <= 1'b0;
            rla_q <= 1'b0;
            long4_q <= 1'b1;
            apmLvl_q <= `APM_MAX_PERF;
            currLim_q <= CURR_MAX;
        end
        else if (state_q == ST_EXEC && known && !badParam)
        begin
            unique case (feat_q)
                `SF_8BIT_ON:     set8_q <= 1'b1;
                `SF_8BIT_OFF:    set8_q <= 1'b0;
                `SF_WCACHE_ON:   wcache_q <= 1'b1;
                `SF_WCACHE_OFF:  wcache_q <= 1'b0;
                `SF_APM_ON:
                begin
                    apm_q <= 1'b1;
                    apmLvl_q <= secCnt_q;
                end
                `SF_APM_OFF:     apm_q <= 1'b0;
                `SF_EXTPWR_ON:   extPwr_q <= 1'b1;
                `SF_EXTPWR_OFF:  extPwr_q <= 1'b0;
                `SF_PL1_ON:      pl1_q <= 1'b1;
                `SF_PL1_OFF:     pl1_q <= 1'b0;
                `SF_RLA_OFF:     rla_q <= 1'b0;
                `SF_RLA_ON:      rla_q <= 1'b1;
                `SF_LONG_4BYTE:  long4_q <= 1'b1;
                `SF_CURR_LIMIT:  currLim_q <= clampCurr(secCnt_q);
                default:         long4_q <= long4_q;
            endcase
        end
    end

    // The keep flag itself survives soft reset, otherwise 66h could never take effect twice.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            porKeep_q <= 1'b0;
        else if (state_q == ST_EXEC && feat_q == `SF_POR_KEEP)
            porKeep_q <= 1'b1;
        else if (state_q == ST_EXEC && feat_q == `SF_POR_RESTORE)
            porKeep_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || restore)
        begin
            pioMode_q <= 3'h0;
            iordyOff_q <= 1'b0;
            dmaMode_q <= 3'h0;
            dmaKind_q <= DMA_CAP ? DMA_MW : DMA_NONE;
        end
        else if (state_q == ST_EXEC && feat_q == `SF_XFER_MODE && !badParam)
        begin
            unique case (xType)
                `XT_PIO_DEFAULT:
                begin
                    pioMode_q <= 3'h0;
                    iordyOff_q <= IORDY_OFF && xMode == `XM_NO_IORDY;
                end
                `XT_PIO_FLOW:
                begin
                    pioMode_q <= xMode;
                    iordyOff_q <= 1'b0;
                end
                `XT_MWDMA:
                begin
                    dmaKind_q <= DMA_MW;
                    dmaMode_q <= xMode;
                end
                `XT_UDMA:
                begin
                    dmaKind_q <= DMA_U;
                    dmaMode_q <= xMode;
                end
                default:
                    dmaMode_q <= dmaMode_q;
            endcase
        end
    end

    // flow control at mode 3 up
    assign iordyEnable = (pioMode_q >= `PIO_IORDY_MIN) || !iordyOff_q;
    assign eightBitMode = set8_q;
    assign wide_io_select_indicator = dataRegAccess && !set8_q;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            acc_q <= 1'b0;
        else
            acc_q <= avs_read && !acc_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            avs_readdata <= 32'h0;
        else if (avs_read && !acc_q)
            unique case (avs_address)
                `OFS_FEATURE:   avs_readdata <= {24'h0, feat_q};
                `OFS_SECCOUNT:  avs_readdata <= {24'h0, secCnt_q};
                `OFS_CYLLOW:    avs_readdata <= {24'h0, cylLow_q};
                `OFS_CYLHIGH:   avs_readdata <= {24'h0, cylHigh_q};
                `OFS_STATUS:    avs_readdata <= {28'h0, flushReq, abort_q, err_q,
                                                 state_q != ST_IDLE};
                `OFS_SETTINGS:  avs_readdata <= {22'h0, iordyEnable, iordyOff_q, porKeep_q,
                                                 long4_q, rla_q, pl1_q, extPwr_q, apm_q,
                                                 wcache_q, set8_q};
                `OFS_MODES:     avs_readdata <= {22'h0, dmaKind_q == DMA_U,
                                                 dmaKind_q == DMA_MW, 1'b0, dmaMode_q,
                                                 1'b0, pioMode_q};
                `OFS_APMLEVEL:  avs_readdata <= {24'h0, apmLvl_q};
                `OFS_CURRLIMIT: avs_readdata <= {24'h0, currLim_q};
                default:        avs_readdata <= 32'h0;
            endcase
    end

    sequence s_issueAbort;
        cmdGo ##1 (state_q == ST_EXEC && (!known || badParam));
    endsequence

    a_abort_on_bad: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_issueAbort |=> abort_q && err_q && $stable(set8_q) && $stable(pioMode_q))
        else $error("Bad subcommand did not abort cleanly");
    a_flush_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_q == ST_FLUSH && !flushDone |=> state_q == ST_FLUSH && flushReq)
        else $error("Completion before cache flush");
    a_dma_exclusive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(dmaKind_q) |-> dmaKind_q != DMA_NONE || !DMA_CAP)
        else $error("DMA selection lost");
    a_iordy_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pioMode_q >= `PIO_IORDY_MIN |-> iordyEnable)
        else $error("Flow control off at high PIO mode");
    a_narrow_io: assert property (@(posedge sys_clk) disable iff (sys_rst)
        set8_q |-> !wide_io_select_indicator)
        else $error("Wide indicator in 8-bit mode");
    a_curr_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
        currLim_q >= CURR_MIN && currLim_q <= CURR_MAX)
        else $error("Current limit outside range");
    a_range_report: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_q == ST_EXEC && feat_q == `SF_CURR_LIMIT |=> cylLow_q == CURR_MIN
        && cylHigh_q == CURR_MAX)
        else $error("Range not reported");
    a_mwdma_card: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_q == ST_EXEC && feat_q == `SF_XFER_MODE && xType == `XT_MWDMA && pcCardMode
        |=> abort_q)
        else $error("MWDMA accepted in card mode");
    a_apm_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
        state_q == ST_EXEC && feat_q == `SF_APM_ON && !validLevel(secCnt_q)
        |=> abort_q && $stable(apmLvl_q))
        else $error("Reserved level stored");
endmodule

// ### ata_host_model.sv
// Host model: Avalon-MM master for the task file, plus the cache flush engine.
// Assumes the decoder takes writes at once and answers reads after a wait.
`timescale 1ns/1ps
module ata_host_model
(
    input  wire logic        sys_clk,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic        avs_waitrequest,
    input  wire logic        flushReq,
    output logic             flushDone
);
    int flushDelay = 2;
    int flushCnt = 0;
    initial
    begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        flushDone = 1'b0;
    end
    // A slow flush keeps the decoder in ST_FLUSH for flushDelay + 2 cycles
    always @(posedge sys_clk)
    begin
        flushCnt <= (flushReq === 1'b1) ? flushCnt + 1 : 0;
        flushDone <= flushReq === 1'b1 && !flushDone && flushCnt >= flushDelay;
    end
    task automatic xfer(input bit r, input logic [3:0] a, input logic [7:0] d, output bit ok);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= r;
        avs_write <= !r;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        ok = avs_waitrequest === 1'b0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Idle write data is scrambled so a stale value is never mistaken for fresh
        avs_writedata <= ~avs_writedata;
    endtask
endmodule

// ### tb_top.sv
// Testbench for the set-features decoder, driven through the host model.
// Assumes the constants header is on the include path; design uses defaults.
`timescale 1ns/1ps
`include "set_features_regs.svh"
module tb_top import set_features_pkg::*;;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic softRst = 1'b0;
    logic pcCardMode = 1'b0;
    logic dataRegAccess = 1'b0;
    logic sawFlush = 1'b0;
    logic flushDone, avs_read, avs_write, avs_waitrequest, wide_io_select_indicator;
    logic eightBitMode, iordyEnable, flushReq;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    int n_errors = 0;
    int tests_run = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (flushReq === 1'b1)
            sawFlush <= 1'b1;
    set_features_subcommand_decoder set_features_subcommand_decoder_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .softRst(softRst), .pcCardMode(pcCardMode),
        .dataRegAccess(dataRegAccess), .flushDone(flushDone), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wide_io_select_indicator(wide_io_select_indicator), .eightBitMode(eightBitMode),
        .iordyEnable(iordyEnable), .flushReq(flushReq));
    ata_host_model ata_host_model_inst (.sys_clk(sys_clk), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_waitrequest(avs_waitrequest), .flushReq(flushReq), .flushDone(flushDone));
    task automatic test_done;
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic bus(input bit r, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        bit ok;
        ata_host_model_inst.xfer(r, a, d, ok);
        q = avs_readdata;
        chk("bus answer", 32'h1, {31'h0, ok});
        if (!ok)
            test_done();
    endtask
    task automatic rg(input string w, input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 8'h0, q);
        chk(w, e, q & m);
    endtask
    // feature and count first, then the command code
    task automatic run(input logic [7:0] f, input logic [7:0] c, output logic [31:0] st,
                       output int n);
        bus(1'b0, `OFS_FEATURE, f, st);
        bus(1'b0, `OFS_SECCOUNT, c, st);
        bus(1'b0, `OFS_COMMAND, `CMD_SET_FEATURES, st);
        st = 32'h1;
        n = 0;
        while (st[`ST_BUSY] !== 1'b0 && n < 100)
        begin
            bus(1'b1, `OFS_STATUS, 8'h0, st);
            n++;
        end
        if (st[`ST_BUSY] !== 1'b0)
        begin
            chk("busy timeout", 32'h0, 32'h1);
            test_done();
        end
    endtask
    task automatic sub(input logic [7:0] f, input logic [7:0] c, input logic ab);
        logic [31:0] st;
        int n;
        run(f, c, st, n);
        chk("abort flag", {31'h0, ab}, {31'h0, st[`ST_ABORT]});
        chk("error flag", {31'h0, ab}, {31'h0, st[`ST_ERROR]});
    endtask
    task automatic t_defaults;
        rg("settings", `OFS_SETTINGS, 32'hff, 32'h40);
        rg("modes", `OFS_MODES, 32'h377, 32'h100);
        rg("current limit", `OFS_CURRLIMIT, 32'hff, 32'h32);
    endtask
    task automatic t_toggles;
        logic [7:0] onC[7] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h0a, 8'haa, 8'h66};
        logic [7:0] offC[7] = '{8'h81, 8'h82, 8'h85, 8'h89, 8'h8a, 8'h55, 8'hcc};
        int bn[7] = '{0, 1, 2, 3, 4, 5, 7};
        for (int i = 0; i < 7; i++)
        begin
            sub(onC[i], 8'hfe, 1'b0);
            rg("setting on", `OFS_SETTINGS, 32'h1 << bn[i], 32'h1 << bn[i]);
            sub(offC[i], 8'hfe, 1'b0);
            rg("setting off", `OFS_SETTINGS, 32'h1 << bn[i], 32'h0);
        end
        sub(`SF_LONG_4BYTE, 8'h0, 1'b0);
        rg("long data", `OFS_SETTINGS, 32'hff, 32'h40);
    endtask
    // here 8-bit mode is tried while dataRegAccess is held high; t_toggles and t_soft set 01h with it low
    task automatic t_eight;
        @(posedge sys_clk);
        dataRegAccess <= 1'b1;
        sub(`SF_8BIT_ON, 8'h0, 1'b0);
        chk("8-bit mode", 32'h1, {31'h0, eightBitMode});
        chk("wide io", 32'h0, {31'h0, wide_io_select_indicator});
        sub(`SF_8BIT_OFF, 8'h0, 1'b0);
        chk("wide io", 32'h1, {31'h0, wide_io_select_indicator});
        @(posedge sys_clk);
        dataRegAccess <= 1'b0;
    endtask
    task automatic t_flush;
        logic [31:0] st;
        int n;
        sub(`SF_WCACHE_ON, 8'h0, 1'b0);
        ata_host_model_inst.flushDelay = 30;
        sawFlush = 1'b0;
        run(`SF_WCACHE_OFF, 8'h0, st, n);
        chk("flush seen", 32'h1, {31'h0, sawFlush});
        chk("busy through flush", 32'h1, {31'h0, n > 5});
        chk("flush request", 32'h0, {31'h0, flushReq});
        ata_host_model_inst.flushDelay = 2;
    endtask
    task automatic t_modes;
        logic [7:0] sc[12] = '{8'h42, 8'h24, 8'h44, 8'h0e, 8'h10, 8'h0f,
                               8'h45, 8'h25, 8'h01, 8'h0b, 8'h02, 8'h00};
        logic ab[12] = '{0, 0, 0, 0, 1, 1, 1, 1, 0, 0, 1, 0};
        logic [31:0] md[12] = '{32'h220, 32'h140, 32'h240, 32'h246, 32'h246, 32'h246,
                                32'h246, 32'h246, 32'h240, 32'h243, 32'h243, 32'h240};
        int io[12] = '{2, 2, 2, 1, 2, 2, 2, 2, 0, 1, 2, 2};
        for (int i = 0; i < 12; i++)
        begin
            sub(`SF_XFER_MODE, sc[i], ab[i]);
            rg("modes", `OFS_MODES, 32'h377, md[i]);
            if (io[i] < 2)
                chk("iordy", io[i], {31'h0, iordyEnable});
        end
        @(posedge sys_clk);
        pcCardMode <= 1'b1;
        sub(`SF_XFER_MODE, 8'h22, 1'b1);
        rg("modes", `OFS_MODES, 32'h377, 32'h240);
        @(posedge sys_clk);
        pcCardMode <= 1'b0;
    endtask
    task automatic t_apm;
        logic [7:0] lv[7] = '{8'h01, 8'h80, 8'h00, 8'h81, 8'hfd, 8'hff, 8'hfe};
        logic [7:0] e = 8'hfe;
        for (int i = 0; i < 7; i++)
        begin
            sub(`SF_APM_ON, lv[i], lv[i] == 8'h00 || lv[i] == 8'hff);
            e = (lv[i] == 8'h00 || lv[i] == 8'hff) ? e : lv[i];
            rg("apm level", `OFS_APMLEVEL, 32'hff, {24'h0, e});
        end
        rg("apm on", `OFS_SETTINGS, 32'h4, 32'h4);
        sub(`SF_APM_OFF, 8'h0, 1'b0);
        rg("apm off", `OFS_SETTINGS, 32'h4, 32'h0);
    endtask
    task automatic t_curr;
        logic [7:0] rq[5] = '{8'h06, 8'hff, 8'h00, 8'h32, 8'h01};
        logic [7:0] ex[5] = '{8'h06, 8'h32, 8'h01, 8'h32, 8'h01};
        for (int i = 0; i < 5; i++)
        begin
            sub(`SF_CURR_LIMIT, rq[i], 1'b0);
            rg("current limit", `OFS_CURRLIMIT, 32'hff, {24'h0, ex[i]});
            rg("range low", `OFS_CYLLOW, 32'hff, 32'h01);
            rg("range high", `OFS_CYLHIGH, 32'hff, 32'h32);
        end
    endtask
    task automatic t_misc;
        logic [7:0] fc[5] = '{8'h69, 8'h96, 8'h97, 8'h42, 8'h00};
        for (int i = 0; i < 5; i++)
            sub(fc[i], 8'h0, i > 2);
        rg("settings kept", `OFS_SETTINGS, 32'hff, 32'h40);
        rg("modes kept", `OFS_MODES, 32'h377, 32'h240);
    endtask
    task automatic pulse;
        @(posedge sys_clk);
        softRst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        softRst <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic t_soft;
        sub(`SF_8BIT_ON, 8'h0, 1'b0);
        sub(`SF_POR_KEEP, 8'h0, 1'b0);
        pulse();
        chk("kept 8-bit", 32'h1, {31'h0, eightBitMode});
        rg("kept current", `OFS_CURRLIMIT, 32'hff, 32'h01);
        sub(`SF_POR_RESTORE, 8'h0, 1'b0);
        pulse();
        chk("restored 8-bit", 32'h0, {31'h0, eightBitMode});
        rg("restored modes", `OFS_MODES, 32'h377, 32'h100);
        rg("restored current", `OFS_CURRLIMIT, 32'hff, 32'h32);
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_toggles();
        t_eight();
        t_flush();
        t_modes();
        t_apm();
        t_curr();
        t_misc();
        t_soft();
        test_done();
    end
endmodule
